/* icfdn_top.sv */
// Behaviour
// - Auto closed: open after dwell above threshold
// - Auto open: close after dwell below threshold
// - One dwell setting serves both directions
// - Higher threshold needs darker scene to open
// - Darkness is a signed value
// - Current darkness readable in every mode
// - Forced-open policy holds filter open
// - Forced-closed policy holds filter closed
// - Pin policy: input active opens filter
// - Report off: output not from position
// - Report on: output follows open position
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module icfdn_top #(
  parameter int DARK_W = 16,
  parameter int TICK_CYCLES = icfdn_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [DARK_W-1:0] measured_darkness,
  input wire logic night_pin_in,
  output logic filter_open,
  output logic report_pin_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Sign extension to the bus word needs at least one spare bit
  if (DARK_W < 2 || DARK_W > 31) begin
    $error("DARK_W must lie in 2..31");
  end

  // ********************************************************************
  // Functions
  // ********************************************************************
  function automatic icfdn_pkg::icfdn_sel_t decode(input logic [7:0] addr);
    icfdn_pkg::icfdn_sel_t sel;
    sel = icfdn_pkg::SEL_NONE;
    if (addr == icfdn_pkg::CTRL_OFF) begin
      sel = icfdn_pkg::SEL_CTRL;
    end else if (addr == icfdn_pkg::THRESH_OFF) begin
      sel = icfdn_pkg::SEL_THRESH;
    end else if (addr == icfdn_pkg::DWELL_OFF) begin
      sel = icfdn_pkg::SEL_DWELL;
    end else if (addr == icfdn_pkg::LEVEL_OFF) begin
      sel = icfdn_pkg::SEL_LEVEL;
    end else if (addr == icfdn_pkg::STATUS_OFF) begin
      sel = icfdn_pkg::SEL_STATUS;
    end
    return sel;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] sext(input logic [DARK_W-1:0] v);
    return {{(32-DARK_W){v[DARK_W-1]}}, v};
  endfunction

  // ********************************************************************
  // Input capture
  // ********************************************************************
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic signed [DARK_W-1:0] level_reg;

  // Pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else if (ce) begin
      pin_meta_reg <= night_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Level comes from the same clock, registered only for timing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_reg <= '0;
    end else if (ce) begin
      level_reg <= $signed(measured_darkness);
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] thresh_reg;
  logic [31:0] dwell_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic do_wr;
  icfdn_pkg::icfdn_sel_t wsel;
  logic [31:0] thresh_merged;
  logic [31:0] dwell_merged;

  assign do_wr = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wsel = decode(awaddr_reg);
  assign thresh_merged = merge(thresh_reg, wdata_reg, wstrb_reg);
  assign dwell_merged = merge(dwell_reg, wdata_reg, wstrb_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= icfdn_pkg::CTRL_RST;
      thresh_reg <= icfdn_pkg::THRESH_RST;
      dwell_reg <= icfdn_pkg::DWELL_RST;
    end else if (ce && do_wr) begin
      if (wsel == icfdn_pkg::SEL_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & icfdn_pkg::CTRL_MASK;
      end else if (wsel == icfdn_pkg::SEL_THRESH) begin
        thresh_reg <= sext(thresh_merged[DARK_W-1:0]);
      end else if (wsel == icfdn_pkg::SEL_DWELL) begin
        dwell_reg <= {16'h0000, dwell_merged[15:0]};
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite write channels
  // ********************************************************************
  logic aw_hs;
  logic w_hs;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;

  always_comb begin
    aw_held_next = do_wr ? 1'b0 : (aw_held_reg | aw_hs);
    w_held_next = do_wr ? 1'b0 : (w_held_reg | w_hs);
    bvalid_next = do_wr ? 1'b1 : (s_axi_bvalid & ~s_axi_bready);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      s_axi_awready <= ~aw_held_next & ~bvalid_next;
      s_axi_wready <= ~w_held_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      if (aw_hs) begin
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Writes to read-only words are dropped but still answered OKAY
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bresp <= icfdn_pkg::RESP_OKAY;
    end else if (ce && do_wr) begin
      s_axi_bresp <= (wsel == icfdn_pkg::SEL_NONE) ? icfdn_pkg::RESP_SLVERR : icfdn_pkg::RESP_OKAY;
    end
  end

  // ********************************************************************
  // Position decision
  // ********************************************************************
  icfdn_dwell_if dw();
  icfdn_pkg::icfdn_policy_t policy;
  icfdn_pkg::icfdn_pos_t pos_reg;
  icfdn_pkg::icfdn_pos_t pos_next;
  logic signed [DARK_W-1:0] thr;
  logic above;
  logic below;
  logic cand;
  logic flip;

  assign policy = icfdn_pkg::icfdn_policy_t'(ctrl_reg[icfdn_pkg::POLICY_LSB +: 2]);
  assign thr = $signed(thresh_reg[DARK_W-1:0]);
  assign above = (level_reg > thr);
  assign below = (level_reg < thr);
  // Equal to threshold counts as neither, so it restarts the wait
  assign cand = (pos_reg == icfdn_pkg::POS_CLOSED) ? above : below;
  assign flip = cand & dw.expired;

  assign dw.run = (policy == icfdn_pkg::POL_AUTO);
  assign dw.restart = ~cand | flip;
  assign dw.dwell_sec = dwell_reg[icfdn_pkg::DWELL_W-1:0];

  icfdn_dwell #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_dwell (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tm(dw)
  );

  always_comb begin
    pos_next = pos_reg;
    case (policy)
      icfdn_pkg::POL_OPEN: begin
        pos_next = icfdn_pkg::POS_OPEN;
      end
      icfdn_pkg::POL_CLOSED: begin
        pos_next = icfdn_pkg::POS_CLOSED;
      end
      icfdn_pkg::POL_PIN: begin
        pos_next = pin_sync_reg ? icfdn_pkg::POS_OPEN : icfdn_pkg::POS_CLOSED;
      end
      default: begin
        // Auto keeps the position it inherits until the wait completes
        case (pos_reg)
          icfdn_pkg::POS_CLOSED: begin
            if (flip) begin
              pos_next = icfdn_pkg::POS_OPEN;
            end
          end
          default: begin
            if (flip) begin
              pos_next = icfdn_pkg::POS_CLOSED;
            end
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_reg <= icfdn_pkg::POS_CLOSED;
      filter_open <= 1'b0;
    end else if (ce) begin
      pos_reg <= pos_next;
      filter_open <= (pos_next == icfdn_pkg::POS_OPEN);
    end
  end

  // ********************************************************************
  // Position report pin
  // ********************************************************************
  // With reporting off the pin is a plain software output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      report_pin_out <= 1'b0;
    end else if (ce) begin
      if (ctrl_reg[icfdn_pkg::REPORT_SEL_BIT]) begin
        report_pin_out <= (pos_next == icfdn_pkg::POS_OPEN);
      end else begin
        report_pin_out <= ctrl_reg[icfdn_pkg::GP_OUT_BIT];
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite read channels
  // ********************************************************************
  logic ar_hs;
  logic rvalid_next;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  icfdn_pkg::icfdn_sel_t rsel;

  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign rsel = decode({s_axi_araddr[7:2], 2'b00});
  assign rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[icfdn_pkg::ST_OPEN_BIT] = (pos_reg == icfdn_pkg::POS_OPEN);
    status_word[icfdn_pkg::ST_PIN_BIT] = pin_sync_reg;
    status_word[icfdn_pkg::ST_REPORT_BIT] = report_pin_out;
    status_word[icfdn_pkg::ST_RUN_BIT] = dw.run;
    status_word[icfdn_pkg::ST_CAND_BIT] = cand;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rsel == icfdn_pkg::SEL_CTRL) begin
      rd_word = ctrl_reg;
    end else if (rsel == icfdn_pkg::SEL_THRESH) begin
      rd_word = thresh_reg;
    end else if (rsel == icfdn_pkg::SEL_DWELL) begin
      rd_word = dwell_reg;
    end else if (rsel == icfdn_pkg::SEL_LEVEL) begin
      rd_word = sext(level_reg);
    end else if (rsel == icfdn_pkg::SEL_STATUS) begin
      rd_word = status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= icfdn_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rsel == icfdn_pkg::SEL_NONE) ? icfdn_pkg::RESP_SLVERR : icfdn_pkg::RESP_OKAY;
      end
    end
  end

endmodule

/* icfdn_pkg.sv */
package icfdn_pkg;

  // ********************************************************************
  // Register map (byte addresses)
  // ********************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] THRESH_OFF = 8'h04;
  localparam logic [7:0] DWELL_OFF = 8'h08;
  localparam logic [7:0] LEVEL_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // ********************************************************************
  // Control fields
  // ********************************************************************
  localparam int POLICY_LSB = 0;
  localparam int REPORT_SEL_BIT = 4;
  localparam int GP_OUT_BIT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0113;

  // Status fields
  localparam int ST_OPEN_BIT = 0;
  localparam int ST_PIN_BIT = 1;
  localparam int ST_REPORT_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int ST_CAND_BIT = 4;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  localparam logic [31:0] DWELL_RST = 32'h0000_0005;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int DWELL_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_UNIT_S = 1;
  localparam int NS_PER_S = 1000000000;
  localparam int SEC_CYCLES = DWELL_UNIT_S * NS_PER_S / CLK_PERIOD_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    POL_AUTO,
    POL_OPEN,
    POL_CLOSED,
    POL_PIN
  } icfdn_policy_t;

  typedef enum logic {
    POS_CLOSED,
    POS_OPEN
  } icfdn_pos_t;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_THRESH,
    SEL_DWELL,
    SEL_LEVEL,
    SEL_STATUS,
    SEL_NONE
  } icfdn_sel_t;

endpackage

/* icfdn_dwell_if.sv */
`timescale 1ns/1ps
interface icfdn_dwell_if;
  logic restart;
  logic run;
  logic [icfdn_pkg::DWELL_W-1:0] dwell_sec;
  logic expired;

  modport ctl (
    output restart,
    output run,
    output dwell_sec,
    input expired
  );

  modport tmr (
    input restart,
    input run,
    input dwell_sec,
    output expired
  );
endinterface

/* icfdn_dwell.sv */
`timescale 1ns/1ps
module icfdn_dwell #(
  parameter int TICK_CYCLES = icfdn_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  icfdn_dwell_if.tmr tm
);

  if (TICK_CYCLES < 1) begin
    $error("TICK_CYCLES must be at least 1");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [icfdn_pkg::DWELL_W-1:0] SEC_STEP = {{(icfdn_pkg::DWELL_W-1){1'b0}}, 1'b1};

  logic [31:0] sub_reg;
  logic [icfdn_pkg::DWELL_W-1:0] sec_reg;
  logic done;

  assign done = (sec_reg >= tm.dwell_sec);
  assign tm.expired = tm.run & done;

  // ********************************************************************
  // Second prescaler and seconds count
  // ********************************************************************
  // Counting saturates at the target so a long stable level never wraps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sub_reg <= 32'h0000_0000;
      sec_reg <= '0;
    end else if (ce) begin
      if (tm.restart || !tm.run) begin
        sub_reg <= 32'h0000_0000;
        sec_reg <= '0;
      end else if (!done) begin
        if (sub_reg == TICK_LAST) begin
          sub_reg <= 32'h0000_0000;
          sec_reg <= sec_reg + SEC_STEP;
        end else begin
          sub_reg <= sub_reg + 32'h0000_0001;
        end
      end
    end
  end

endmodule

/* icfdn_photocell.sv */
`timescale 1ns/1ps
// ********************************************************************
// Photocell switch and illuminator relay
// ********************************************************************
module icfdn_photocell (
  input wire logic clk,
  input wire logic dark,
  input wire logic report_pin_out,
  output logic night_pin_in,
  output logic lamp_on
);
  // Contact moves on a clock edge, closed at night
  always_ff @(posedge clk) begin
    night_pin_in <= dark;
  end
  // Relay coil simply follows the output pin
  assign lamp_on = report_pin_out;
endmodule

/* icfdn_top_checker.sv */
`timescale 1ns/1ps
module icfdn_top_checker #(
  parameter int DARK_W = 16,
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [DARK_W-1:0] measured_darkness,
  input wire logic night_pin_in,
  input wire logic filter_open,
  input wire logic report_pin_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // ********************************************************************
  // Register mirror, updated at the write response
  // ********************************************************************
  logic [7:0] a_q;
  logic [31:0] d_q;
  logic [8:0] ctrl_m;
  logic signed [DARK_W-1:0] thr_m;
  logic [15:0] dw_m;
  logic cand;
  int run_c;
  assign cand = ctrl_m[1:0] == 2'h0 &&
    (filter_open ? $signed(measured_darkness) < thr_m : $signed(measured_darkness) > thr_m);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_m <= '0;
      thr_m <= '0;
      dw_m <= 16'h0005;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
        case (a_q)
          8'h00: ctrl_m <= d_q[8:0] & 9'h113;
          8'h04: thr_m <= d_q[DARK_W-1:0];
          8'h08: dw_m <= d_q[15:0];
          default: ;
        endcase
      end
    end
  end
  // Counts from the port value, so it leads the design by the input register
  always_ff @(posedge clk) begin
    if (!rst_n || !cand) run_c <= 0;
    else if (ce) run_c <= run_c + 1;
  end
  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  sequence pin_steady;
    (ctrl_m[1:0] == 2'h3 && $stable(night_pin_in)) [*4];
  endsequence
  forced_open_a: assert property (ctrl_m[1:0] == 2'h1 |-> filter_open)
    else $error("filter closed under forced open");
  forced_closed_a: assert property (ctrl_m[1:0] == 2'h2 |-> !filter_open)
    else $error("filter open under forced closed");
  pin_follow_a: assert property (pin_steady |=> ctrl_m[1:0] != 2'h3 || filter_open == $past(night_pin_in))
    else $error("filter does not follow pin");
  report_on_a: assert property (ctrl_m[4] |-> report_pin_out == filter_open)
    else $error("report pin differs from position");
  report_off_a: assert property (!ctrl_m[4] |-> report_pin_out == ctrl_m[8])
    else $error("report pin not from software level");
  auto_early_a: assert property (ctrl_m[1:0] == 2'h0 && $past(ctrl_m[1:0]) == 2'h0 && $changed(filter_open)
    |-> $past(run_c) >= dw_m * TICK_CYCLES) else $error("filter switched before dwell");
  auto_late_a: assert property (run_c <= dw_m * TICK_CYCLES + 4)
    else $error("filter did not switch after dwell");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind icfdn_top icfdn_top_checker #(.DARK_W(DARK_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk, .rst_n, .ce, .measured_darkness, .night_pin_in, .filter_open, .report_pin_out,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* icfdn_top_test.sv */
`timescale 1ns/1ps
module icfdn_top_test;
  // ********************************************************************
  // Bench signals
  // ********************************************************************
  logic clk, rst_n, ce, night, lamp, night_pin_in, filter_open, report_pin_out;
  logic [15:0] measured_darkness;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count, n_compared;
  // Short tick of 4 cycles keeps the 2 s dwell to 8 cycles
  icfdn_top #(.DARK_W(16), .TICK_CYCLES(4)) u_dut (
    .clk, .rst_n, .ce, .measured_darkness, .night_pin_in, .filter_open, .report_pin_out,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  icfdn_photocell u_cell (.clk, .dark(night), .report_pin_out, .night_pin_in, .lamp_on(lamp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !dd) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid && ad && dd));
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, icfdn_pkg::RESP_OKAY);
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset;
    rd(8'h00);
    chk("ctrl reset", rv, 32'h0);
    rd(8'h08);
    chk("dwell reset", rv, 32'h5);
    chk("filter reset", filter_open, 32'h0);
  endtask
  task automatic t_auto;
    wr(8'h04, 32'hFFFF_FFFE);
    wr(8'h08, 32'h0000_0002);
    wr(8'h00, 32'h0000_0010);
    measured_darkness <= 16'hFFFE;
    cyc(12);
    chk("level equal", filter_open, 32'h0);
    measured_darkness <= 16'hFFFF;
    cyc(6);
    measured_darkness <= 16'hFFFB;
    cyc(1);
    measured_darkness <= 16'hFFFF;
    cyc(8);
    chk("after glitch", filter_open, 32'h0);
    cyc(6);
    chk("night open", filter_open, 32'h1);
    chk("lamp on", lamp, 32'h1);
    measured_darkness <= 16'hFFFD;
    cyc(6);
    chk("still open", filter_open, 32'h1);
    cyc(8);
    chk("day closed", filter_open, 32'h0);
    rd(8'h0C);
    chk("level read", rv, 32'hFFFF_FFFD);
    rd(8'h20);
    chk("unmapped resp", rs, icfdn_pkg::RESP_SLVERR);
    chk("unmapped data", rv, 32'h0);
  endtask
  task automatic t_forced;
    wr(8'h00, 32'h0000_0011);
    chk("forced open", filter_open, 32'h1);
    measured_darkness <= 16'h0064;
    wr(8'h00, 32'h0000_0012);
    cyc(20);
    chk("forced closed", filter_open, 32'h0);
    chk("lamp off", lamp, 32'h0);
    wr(8'h00, 32'h0000_0102);
    chk("report off high", report_pin_out, 32'h1);
    wr(8'h00, 32'h0000_0001);
    chk("report off low", report_pin_out, 32'h0);
  endtask
  task automatic t_pin;
    wr(8'h00, 32'h0000_0013);
    rd(8'h0C);
    chk("level in pin mode", rv, 32'h0000_0064);
    night <= 1'b1;
    cyc(6);
    chk("pin night", filter_open, 32'h1);
    night <= 1'b0;
    cyc(6);
    chk("pin day", filter_open, 32'h0);
    // Enable low must freeze the position even though the pin moves
    ce <= 1'b0;
    night <= 1'b1;
    cyc(8);
    chk("frozen", filter_open, 32'h0);
    ce <= 1'b1;
    cyc(6);
    chk("thawed", filter_open, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    night = 1'b0;
    measured_darkness = 16'hFFFB;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    t_reset;
    t_auto;
    t_forced;
    t_pin;
    report_and_stop;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    cyc(3000);
    bad_count++;
    report_and_stop;
  end
endmodule
